// ==== logic/cie_pkg.sv ====
// Constants and register layout of the interrupt code encoder.
package cie_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] CIE_OFS_STATUS   = 5'h00;
  localparam logic [4:0] CIE_OFS_FLAGS    = 5'h04;
  localparam logic [4:0] CIE_OFS_ENABLE   = 5'h08;
  localparam logic [4:0] CIE_OFS_IRQSTAT  = 5'h0c;
  localparam logic [4:0] CIE_OFS_IRQMASK  = 5'h10;

  // Bit positions shared by the flag, enable, interrupt status and mask registers.
  localparam int CIE_NSRC       = 8;
  localparam int CIE_B_ERR      = 0;
  localparam int CIE_B_TX0      = 1;
  localparam int CIE_B_TX1      = 2;
  localparam int CIE_B_TX2      = 3;
  localparam int CIE_B_RX0      = 4;
  localparam int CIE_B_RX1      = 5;
  localparam int CIE_B_WAKE     = 6;
  localparam int CIE_B_MSGERR   = 7;

  // Position of the source code field inside the controller status word.
  localparam int CIE_CODE_LSB   = 1;
  localparam int CIE_CODE_MSB   = 3;

  // Values after reset.
  localparam logic [7:0] CIE_RST_FLAGS   = 8'h00;
  localparam logic [7:0] CIE_RST_ENABLE  = 8'h00;
  localparam logic [7:0] CIE_RST_IRQSTAT = 8'h00;
  localparam logic [7:0] CIE_RST_IRQMASK = 8'h00;

  // Source codes; priority runs error, tx 0..2, rx 0..1, wake-up, which does not follow the code value.
  localparam logic [2:0] CIE_CODE_NONE  = 3'h0;
  localparam logic [2:0] CIE_CODE_ERR   = 3'h1;
  localparam logic [2:0] CIE_CODE_TX2   = 3'h2;
  localparam logic [2:0] CIE_CODE_TX1   = 3'h3;
  localparam logic [2:0] CIE_CODE_TX0   = 3'h4;
  localparam logic [2:0] CIE_CODE_RX1   = 3'h5;
  localparam logic [2:0] CIE_CODE_RX0   = 3'h6;
  localparam logic [2:0] CIE_CODE_WAKE  = 3'h7;

endpackage : cie_pkg

// ==== logic/cie_src_if.sv ====
// Interface carrying flags, enables and the encoded source code.
`timescale 1ns/1ps
interface cie_src_if;
  logic [7:0] flags;
  logic [7:0] enables;
  logic [2:0] code;
  logic       anyPending;

  modport enc (
    input  flags,
    input  enables,
    output code,
    output anyPending
  );

  modport ctl (
    output flags,
    output enables,
    input  code,
    input  anyPending
  );
endinterface : cie_src_if

// ==== logic/cie_code_encoder.sv ====
// Priority encoder from pending enabled sources to the 3-bit source code.
`timescale 1ns/1ps
module cie_code_encoder (
  // Clock and reset, used by the checks only.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Sources and code.
  cie_src_if.enc   src
);
  import cie_pkg::*;

  // Highest priority first: error, tx 0..2, rx 0..1, wake-up.
  function automatic logic [2:0] cieEncode(input logic [6:0] p);
    logic [2:0] c;
    c = CIE_CODE_NONE;
    if (p[CIE_B_ERR]) begin
      c = CIE_CODE_ERR;
    end else if (p[CIE_B_TX0]) begin
      c = CIE_CODE_TX0;
    end else if (p[CIE_B_TX1]) begin
      c = CIE_CODE_TX1;
    end else if (p[CIE_B_TX2]) begin
      c = CIE_CODE_TX2;
    end else if (p[CIE_B_RX0]) begin
      c = CIE_CODE_RX0;
    end else if (p[CIE_B_RX1]) begin
      c = CIE_CODE_RX1;
    end else if (p[CIE_B_WAKE]) begin
      c = CIE_CODE_WAKE;
    end
    return c;
  endfunction : cieEncode

  wire logic [6:0] pending;

  assign pending = src.flags[6:0] & src.enables[6:0];
  assign src.code = cieEncode(pending);
  assign src.anyPending = |pending;

  noneCode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (pending == 7'h00) |-> (src.code == CIE_CODE_NONE))
    else $error("Code not zero with nothing pending.");

  errTop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    pending[CIE_B_ERR] |-> (src.code == CIE_CODE_ERR))
    else $error("Error source not given top priority.");

  txOrder_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!pending[CIE_B_ERR] && pending[CIE_B_TX1] && !pending[CIE_B_TX0])
    |-> (src.code == CIE_CODE_TX1))
    else $error("Transmit buffer 1 code wrong.");

  rxOrder_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (pending[3:0] == 4'h0 && pending[CIE_B_RX1] && !pending[CIE_B_RX0])
    |-> (src.code == CIE_CODE_RX1))
    else $error("Receive buffer 1 code wrong.");

  wakeLast_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (src.code == CIE_CODE_WAKE) |->
    (pending[CIE_B_WAKE] && pending[5:0] == 6'h00))
    else $error("Wake code shown while a higher source pends.");

  maskedOff_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (src.code != CIE_CODE_NONE) |->
    (src.enables[src.code == CIE_CODE_ERR ? CIE_B_ERR :
      src.code == CIE_CODE_TX0 ? CIE_B_TX0 :
      src.code == CIE_CODE_TX1 ? CIE_B_TX1 :
      src.code == CIE_CODE_TX2 ? CIE_B_TX2 :
      src.code == CIE_CODE_RX0 ? CIE_B_RX0 :
      src.code == CIE_CODE_RX1 ? CIE_B_RX1 : CIE_B_WAKE]))
    else $error("Code names a source whose enable is off.");

  wakeSeen_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    src.code == CIE_CODE_WAKE);

endmodule : cie_code_encoder

// ==== logic/cie_top.sv ====
// Interrupt code encoder with flag, enable and interrupt registers on Avalon.
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module cie_top (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave.
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Source events from the CAN core, one-cycle pulses.
  input  wire logic        errorEvent,
  input  wire logic        txBuf0Done,
  input  wire logic        txBuf1Done,
  input  wire logic        txBuf2Done,
  input  wire logic        rxBuf0Full,
  input  wire logic        rxBuf1Full,
  input  wire logic        wakeupEvent,
  input  wire logic        busErrorDetect,
  input  wire logic        msgInProgress,
  // Interrupt outputs.
  output logic             irq,
  output logic             msgErrorIrq,
  output logic             canIrq,
  output logic      [2:0]  irqSourceCode
);
  import cie_pkg::*;

  cie_src_if src ();

  logic [7:0]  flags_q;
  logic [7:0]  flags_d;
  logic [7:0]  enables_q;
  logic [7:0]  enables_d;
  logic [7:0]  irqStat_q;
  logic [7:0]  irqStat_d;
  logic [7:0]  irqMask_q;
  logic [7:0]  irqMask_d;
  logic        ack_q;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;

  wire logic        reqActive;
  wire logic        accept;
  wire logic        lowLane;
  wire logic        wrFlags;
  wire logic        wrEnable;
  wire logic        wrMask;
  wire logic        rdIrqStat;
  wire logic [7:0]  setVec;
  wire logic [7:0]  flagClr;
  wire logic [7:0]  statClr;
  wire logic [31:0] statusWord;
  wire logic [31:0] rdMux;

  cie_code_encoder u_encoder (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .src      (src.enc)
  );

  assign src.flags   = flags_q;
  assign src.enables = enables_q;

  // Every access takes one wait cycle, the answer comes on the second edge.
  assign reqActive = avs_read | avs_write;
  assign accept    = reqActive & ack_q;
  assign avs_waitrequest = reqActive & ~ack_q;
  assign lowLane   = avs_byteenable[0];
  assign wrFlags   = accept & avs_write & lowLane &
                     (avs_address == CIE_OFS_FLAGS);
  assign wrEnable  = accept & avs_write & lowLane &
                     (avs_address == CIE_OFS_ENABLE);
  assign wrMask    = accept & avs_write & lowLane &
                     (avs_address == CIE_OFS_IRQMASK);
  assign rdIrqStat = accept & avs_read & (avs_address == CIE_OFS_IRQSTAT);

  // Hardware events that set the flags.
  assign setVec[CIE_B_ERR]    = errorEvent;
  assign setVec[CIE_B_TX0]    = txBuf0Done;
  assign setVec[CIE_B_TX1]    = txBuf1Done;
  assign setVec[CIE_B_TX2]    = txBuf2Done;
  assign setVec[CIE_B_RX0]    = rxBuf0Full;
  assign setVec[CIE_B_RX1]    = rxBuf1Full;
  assign setVec[CIE_B_WAKE]   = wakeupEvent;
  assign setVec[CIE_B_MSGERR] = busErrorDetect & msgInProgress;

  // Writing zero clears a flag, writing one leaves it, a new event wins.
  assign flagClr = wrFlags ? ~avs_writedata[7:0] : 8'h00;
  assign flags_d = (flags_q & ~flagClr) | setVec;
  assign enables_d = wrEnable ? avs_writedata[7:0] : enables_q;
  assign irqMask_d = wrMask ? avs_writedata[7:0] : irqMask_q;

  // Only the bits that were returned are cleared, so a late event survives.
  assign statClr   = rdIrqStat ? rdData_q[7:0] : 8'h00;
  assign irqStat_d = (irqStat_q & ~statClr) | setVec;

  assign statusWord = {28'h0000000, src.code, 1'b0};

  assign rdMux =
    (avs_address == CIE_OFS_STATUS)  ? statusWord :
    (avs_address == CIE_OFS_FLAGS)   ? {24'h000000, flags_q} :
    (avs_address == CIE_OFS_ENABLE)  ? {24'h000000, enables_q} :
    (avs_address == CIE_OFS_IRQSTAT) ? {24'h000000, irqStat_q} :
    (avs_address == CIE_OFS_IRQMASK) ? {24'h000000, irqMask_q} :
    32'h00000000;

  // Read data is captured in the wait cycle and held through the answer.
  assign rdData_d = (avs_read & ~ack_q) ? rdMux : rdData_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q   <= CIE_RST_FLAGS;
      enables_q <= CIE_RST_ENABLE;
      irqStat_q <= CIE_RST_IRQSTAT;
      irqMask_q <= CIE_RST_IRQMASK;
    end else begin
      flags_q   <= flags_d;
      enables_q <= enables_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q    <= 1'b0;
      rdData_q <= 32'h00000000;
    end else begin
      ack_q    <= reqActive & ~ack_q;
      rdData_q <= rdData_d;
    end
  end

  assign avs_readdata  = rdData_q;
  assign irqSourceCode = src.code;
  assign canIrq        = src.anyPending;
  assign msgErrorIrq   = flags_q[CIE_B_MSGERR] &
                         enables_q[CIE_B_MSGERR];
  assign irq           = |(irqStat_q & irqMask_q);

  statusField_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (avs_read && !ack_q && avs_address == CIE_OFS_STATUS) |=>
    (avs_readdata[CIE_CODE_MSB:CIE_CODE_LSB] == $past(src.code) &&
     avs_readdata[0] == 1'b0))
    else $error("Status word does not carry the source code.");

  msgErrSet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (busErrorDetect && msgInProgress) |=> flags_q[CIE_B_MSGERR])
    else $error("Message-error flag not set after bus error.");

  msgErrIrq_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    msgErrorIrq |->
    (flags_q[CIE_B_MSGERR] && enables_q[CIE_B_MSGERR]))
    else $error("Message-error request without flag and enable.");

  nextCode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrFlags && !avs_writedata[CIE_B_ERR] && !setVec[CIE_B_ERR] &&
     flags_q[CIE_B_ERR] && enables_q[CIE_B_ERR] &&
     flags_q[CIE_B_TX0] && enables_q[CIE_B_TX0] &&
     avs_writedata[CIE_B_TX0] && !wrEnable)
    |=> (irqSourceCode == CIE_CODE_TX0))
    else $error("Next pending code not shown after clearing error.");

  noSelfClear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($fell(flags_q[CIE_B_TX0]) || $fell(flags_q[CIE_B_RX0])) |->
    $past(wrFlags))
    else $error("Buffer flag cleared without a software write.");

  setWins_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (wrFlags && txBuf1Done) |=> flags_q[CIE_B_TX1])
    else $error("Event lost while its flag was being cleared.");

  liveCode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (enables_q[CIE_B_ERR] && flags_q[CIE_B_ERR]) |->
    (irqSourceCode == CIE_CODE_ERR))
    else $error("Code lags the present flags.");

  busAnswer_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reqActive |-> ##[0:1] !avs_waitrequest)
    else $error("Bus answer later than one wait cycle.");

  errCode_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    irqSourceCode == CIE_CODE_ERR ##1 irqSourceCode == CIE_CODE_TX0);

  readClear_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    rdIrqStat && irqStat_q != 8'h00);

  msgErr_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    msgErrorIrq);

endmodule : cie_top

// ==== dv/tb_top.sv ====
// Self-checking bench for the interrupt code encoder.
`timescale 1ns/1ps
module tb_top;
  import cie_pkg::*;

  typedef struct packed {
    logic [7:0] ev;
    logic [7:0] en;
    logic [2:0] code;
  } cie_row_t;

  logic        core_clk      = 1'b0;
  logic        sys_rst       = 1'b1;
  logic [4:0]  avsAddress    = 5'h00;
  logic        avsRead       = 1'b0;
  logic        avsWrite      = 1'b0;
  logic [31:0] avsWritedata  = 32'h00000000;
  logic [31:0] avsReaddata;
  logic        avsWaitreq;
  logic [6:0]  ev            = 7'h00;
  logic        busErr        = 1'b0;
  logic        msgAct        = 1'b0;
  logic        irq;
  logic        msgErrorIrq;
  logic        canIrq;
  logic [2:0]  irqSourceCode;
  logic [31:0] q;
  int          errorCnt      = 0;
  int          checked       = 0;
  int          cyc           = 0;

  // Bit 7 of ev marks a bus error seen during a message.
  cie_row_t rows [13] = '{
    '{8'h00, 8'hff, CIE_CODE_NONE}, '{8'h7f, 8'hff, CIE_CODE_ERR},
    '{8'h7e, 8'hff, CIE_CODE_TX0},  '{8'h7c, 8'hff, CIE_CODE_TX1},
    '{8'h78, 8'hff, CIE_CODE_TX2},  '{8'h70, 8'hff, CIE_CODE_RX0},
    '{8'h60, 8'hff, CIE_CODE_RX1},  '{8'h40, 8'hff, CIE_CODE_WAKE},
    '{8'h7f, 8'hfe, CIE_CODE_TX0},  '{8'h7f, 8'h40, CIE_CODE_WAKE},
    '{8'h3f, 8'hc0, CIE_CODE_NONE}, '{8'h80, 8'hff, CIE_CODE_NONE},
    '{8'h80, 8'h7f, CIE_CODE_NONE}
  };
  logic [2:0] nxt [7] = '{CIE_CODE_TX0, CIE_CODE_TX1, CIE_CODE_TX2,
    CIE_CODE_RX0, CIE_CODE_RX1, CIE_CODE_WAKE, CIE_CODE_NONE};

  cie_top cie_top_i (
    .core_clk        (core_clk),
    .sys_rst         (sys_rst),
    .avs_address     (avsAddress),
    .avs_read        (avsRead),
    .avs_write       (avsWrite),
    .avs_writedata   (avsWritedata),
    .avs_byteenable  (4'hf),
    .avs_readdata    (avsReaddata),
    .avs_waitrequest (avsWaitreq),
    .errorEvent      (ev[0]),
    .txBuf0Done      (ev[1]),
    .txBuf1Done      (ev[2]),
    .txBuf2Done      (ev[3]),
    .rxBuf0Full      (ev[4]),
    .rxBuf1Full      (ev[5]),
    .wakeupEvent     (ev[6]),
    .busErrorDetect  (busErr),
    .msgInProgress   (msgAct),
    .irq             (irq),
    .msgErrorIrq     (msgErrorIrq),
    .canIrq          (canIrq),
    .irqSourceCode   (irqSourceCode)
  );

  always #10 core_clk = ~core_clk;

  task automatic testDone;
    $display("Checks %0d, errors %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : testDone

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt++;
      testDone();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      errorCnt++;
    end
  endtask : chk

  // One Avalon transfer; the request is held until waitrequest is low.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    avsAddress   <= a;
    avsWrite     <= wr;
    avsRead      <= ~wr;
    avsWritedata <= {24'h000000, d};
    // Waitrequest and read data are taken at the rising edge itself.
    do begin
      @(posedge core_clk);
      n++;
    end while (avsWaitreq !== 1'b0 && n < 40);
    if (n >= 40) begin
      errorCnt++;
    end
    r = avsReaddata;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, {24'h000000, e});
  endtask : rd

  task automatic pulse(input logic [7:0] e);
    @(posedge core_clk);
    ev     <= e[6:0];
    busErr <= e[7];
    msgAct <= e[7];
    @(posedge core_clk);
    ev     <= 7'h00;
    busErr <= 1'b0;
    msgAct <= 1'b0;
    @(negedge core_clk);
  endtask : pulse

  task automatic code(input logic [2:0] e);
    @(negedge core_clk);
    chk({29'h0, irqSourceCode}, {29'h0, e});
  endtask : code

  task automatic lvl(input logic e);
    @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : lvl

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    code(CIE_CODE_NONE);
    rd(CIE_OFS_FLAGS, CIE_RST_FLAGS);
    rd(CIE_OFS_ENABLE, CIE_RST_ENABLE);
    rd(CIE_OFS_IRQSTAT, CIE_RST_IRQSTAT);
    rd(CIE_OFS_IRQMASK, CIE_RST_IRQMASK);
    foreach (rows[i]) begin
      wr(CIE_OFS_FLAGS, 8'h00);
      wr(CIE_OFS_ENABLE, rows[i].en);
      pulse(rows[i].ev);
      code(rows[i].code);
      rd(CIE_OFS_STATUS, {4'h0, rows[i].code, 1'b0});
      rd(CIE_OFS_FLAGS, rows[i].ev);
      chk({31'h0, canIrq}, {31'h0, |(rows[i].ev[6:0] & rows[i].en[6:0])});
      chk({31'h0, msgErrorIrq}, {31'h0, rows[i].ev[7] & rows[i].en[7]});
    end
    // Flags must survive idle time and fall only by software writes.
    wr(CIE_OFS_FLAGS, 8'h00);
    wr(CIE_OFS_ENABLE, 8'hff);
    pulse(8'h7f);
    repeat (10) @(posedge core_clk);
    rd(CIE_OFS_FLAGS, 8'h7f);
    for (int i = 0; i < 7; i++) begin
      wr(CIE_OFS_FLAGS, ~(8'h01 << i));
      code(nxt[i]);
    end
    // A bus error outside a message, or a message alone, sets nothing.
    @(posedge core_clk);
    busErr <= 1'b1;
    @(posedge core_clk);
    busErr <= 1'b0;
    msgAct <= 1'b1;
    @(posedge core_clk);
    msgAct <= 1'b0;
    rd(CIE_OFS_FLAGS, 8'h00);
    wr(CIE_OFS_IRQMASK, 8'h00);
    bus(1'b0, CIE_OFS_IRQSTAT, 8'h00, q);
    pulse(8'h02);
    lvl(1'b0);
    wr(CIE_OFS_IRQMASK, 8'h02);
    lvl(1'b1);
    rd(CIE_OFS_IRQSTAT, 8'h02);
    lvl(1'b0);
    rd(CIE_OFS_IRQSTAT, 8'h00);
    wr(5'h14, 8'h00);
    rd(5'h14, 8'h00);
    rd(CIE_OFS_ENABLE, 8'hff);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(CIE_OFS_ENABLE, CIE_RST_ENABLE);
    rd(CIE_OFS_FLAGS, CIE_RST_FLAGS);
    code(CIE_CODE_NONE);
    testDone();
  end
endmodule : tb_top
